/* clkgen_pkg.sv */
/*
 Constants shared by the base clock selector and PLL control block:
 register addresses, field positions, reset values and switch counts.
 Assumes a byte-wide register port with a two-bit address.
*/
package clkgen_pkg;
   ////////////////////////////////////////////////////////////////////
   // Register addresses
   localparam int ADDR_W = 2;
   localparam logic [1:0] PLL_CTRL_ADDR = 2'h0; // Control register
   localparam logic [1:0] BW_CTRL_ADDR = 2'h1; // Bandwidth control
   localparam logic [1:0] PROG_ADDR = 2'h2; // Multiplier and range
   localparam int DATA_W = 8;
   ////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int IE_BIT = 7; // Lock interrupt enable
   localparam int FLAG_BIT = 6; // Lock change flag
   localparam int ON_BIT = 5; // PLL power on
   localparam int BCS_BIT = 4; // Base clock select
   localparam logic [3:0] CTRL_LOW_ONES = 4'hF; // Unused bits read high
   localparam logic PLL_ON_RST = 1'b1; // PLL runs from power-up
   ////////////////////////////////////////////////////////////////////
   // Bandwidth register fields
   localparam int AUTO_BIT = 7; // Automatic bandwidth mode
   localparam int LOCK_BIT = 6; // Lock indicator
   ////////////////////////////////////////////////////////////////////
   // Programming register fields
   localparam int MUL_HI = 7;
   localparam int MUL_LO = 4;
   localparam int VRS_HI = 3;
   localparam int VRS_LO = 0;
   localparam logic [3:0] MUL_RST = 4'h6; // Default multiplier
   localparam logic [3:0] VRS_RST = 4'h6; // Default range
   localparam logic [3:0] FIELD_ZERO = 4'h0;
   localparam logic [3:0] MUL_ONE = 4'h1;
   ////////////////////////////////////////////////////////////////////
   // Source switch
   localparam logic [1:0] SWITCH_EDGES = 2'h3; // Edges waited per source
   localparam int SYNC_W = 3; // Lock, crystal, VCO samples
endpackage

/* level_sync.sv */
/*
 Two-flop synchroniser for a vector of independent levels.
 Assumes each bit is a slowly changing level or a clock far below clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Levels
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   if (WIDTH < 1) begin : g_width_check
      $error("level_sync: WIDTH must be at least 1");
   end
   ////////////////////////////////////////////////////////////////////
   logic [WIDTH-1:0] meta_r; // First stage, read only by the second
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r; // Second stage
   logic [WIDTH-1:0] sync_nxt;
   // Next values
   always_comb begin
      meta_nxt = async_i;
      sync_nxt = meta_r;
   end
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end
   assign sync_o = sync_r;
endmodule // level_sync
`default_nettype wire

/* clk_switch.sv */
/*
 Glitch-free source switch and divide-by-two for the base clock.
 Assumes both source clocks arrive as synchronised samples of clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module clk_switch (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Sources
   input wire logic xclk_i,
   input wire logic vclk_i,
   input wire logic vco_live_i,
   input wire logic osc_en_i,
   // Selection and output
   input wire logic sel_i,
   output logic base_clock_o,
   output logic busy_o
);
   import clkgen_pkg::*;
   ////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {ST_RUN, ST_OLD, ST_NEW} sw_state_t;
   sw_state_t state_r, state_nxt; // Transition state
   logic x_prev_r, x_prev_nxt; // Edge detect history
   logic v_prev_r, v_prev_nxt;
   logic cur_r, cur_nxt; // Source in use, 1 = VCO
   logic [1:0] cnt_r, cnt_nxt; // Edges seen in this phase
   logic out_r, out_nxt; // Divided output
   logic x_rise, v_rise, old_edge, new_edge, old_dead;
   ////////////////////////////////////////////////////////////////////
   // Edge selection
   always_comb begin
      x_rise = xclk_i & ~x_prev_r;
      v_rise = vclk_i & ~v_prev_r;
      old_edge = cur_r ? v_rise : x_rise;
      new_edge = cur_r ? x_rise : v_rise;
      old_dead = cur_r & ~vco_live_i; // A dead VCO gives no edges
   end
   // Next state
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      cur_nxt = cur_r;
      out_nxt = out_r;
      x_prev_nxt = xclk_i;
      v_prev_nxt = vclk_i;
      case (state_r)
         ST_RUN: begin
            if (sel_i != cur_r) begin
               state_nxt = ST_OLD;
               cnt_nxt = '0;
            end else if (old_edge) begin
               out_nxt = ~out_r;
            end
         end
         ST_OLD: begin
            // Output static while the old source drains
            if (old_dead || (old_edge && cnt_r == SWITCH_EDGES - 2'h1)) begin
               state_nxt = ST_NEW;
               cnt_nxt = '0;
            end else if (old_edge) begin
               cnt_nxt = cnt_r + 2'h1;
            end
         end
         ST_NEW: begin
            // Then three edges of the new source
            if (new_edge && cnt_r == SWITCH_EDGES - 2'h1) begin
               state_nxt = ST_RUN;
               cur_nxt = ~cur_r;
            end else if (new_edge) begin
               cnt_nxt = cnt_r + 2'h1;
            end
         end
         default: state_nxt = ST_RUN;
      endcase
      if (!osc_en_i) begin
         // Oscillator gated: output low, crystal source
         state_nxt = ST_RUN;
         cur_nxt = 1'b0;
         out_nxt = 1'b0;
         cnt_nxt = '0;
      end
   end
   // Registers
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_r <= ST_RUN;
         cnt_r <= '0;
         cur_r <= 1'b0;
         out_r <= 1'b0;
         x_prev_r <= 1'b0;
         v_prev_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         cur_r <= cur_nxt;
         out_r <= out_nxt;
         x_prev_r <= x_prev_nxt;
         v_prev_r <= v_prev_nxt;
      end
   end
   assign base_clock_o = out_r;
   assign busy_o = (state_r != ST_RUN);
   ////////////////////////////////////////////////////////////////////
   // Checks
   AST_STASIS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (state_r != ST_RUN) && osc_en_i |=> $stable(out_r))
      else $error("base clock moved during a source transition");
   AST_DIV_EDGE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (state_r == ST_RUN) && (sel_i == cur_r) && osc_en_i && !old_edge |=> $stable(out_r))
      else $error("base clock toggled without a source edge");
   COV_SWITCH: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      state_r == ST_NEW ##[1:200] state_r == ST_RUN);
endmodule // clk_switch
`default_nettype wire

/* pll_ctl.sv */
/*
 PLL control registers and base clock selection.
 Assumes a byte-wide register port with one-cycle strobes and read data in
 the following cycle, and clock and lock inputs sampled on clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pll_ctl (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Register port
   input wire logic [clkgen_pkg::ADDR_W-1:0] addr_i,
   input wire logic [clkgen_pkg::DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [clkgen_pkg::DATA_W-1:0] rdata_o,
   // System integration unit
   input wire logic osc_enable_in_i,
   input wire logic stop_i,
   output logic base_clock_out_o,
   output logic pll_irq_out_o,
   // Analog side
   input wire logic crystal_clock_i,
   input wire logic vco_clock_i,
   input wire logic lock_detect_i,
   output logic pll_enable_o,
   output logic osc_run_o,
   output logic [3:0] fb_divider_o,
   output logic [3:0] vco_range_field_o,
   output logic switch_busy_o
);
   import clkgen_pkg::*;
   ////////////////////////////////////////////////////////////////////
   // State
   logic ie_r, ie_nxt; // Lock interrupt enable
   logic flag_r, flag_nxt; // Lock change flag
   logic on_r, on_nxt; // PLL power on
   logic bcs_r, bcs_nxt; // Base clock select
   logic auto_r, auto_nxt; // Automatic bandwidth mode
   logic [3:0] mul_r, mul_nxt; // Feedback multiplier
   logic [3:0] vrs_r, vrs_nxt; // VCO range field
   logic lock_prev_r, lock_prev_nxt; // Last synchronised lock
   logic [DATA_W-1:0] rdata_r, rdata_nxt; // Read data
   logic [SYNC_W-1:0] sync_in, sync_out; // Synchroniser vector
   logic lock_s, xclk_s, vclk_s; // Synchronised inputs
   logic wr_ctrl, wr_bw, wr_prog, rd_ctrl; // Decoded strobes
   logic toggle; // Lock changed
   logic vrs_ok; // Range field nonzero
   logic [3:0] vrs_eff; // Range after this write
   logic [DATA_W-1:0] ctrl_view, bw_view, prog_view;
   ////////////////////////////////////////////////////////////////////
   // Input synchronisation
   // Lock and both clocks, two flops
   assign sync_in = {lock_detect_i, crystal_clock_i, vco_clock_i};
   level_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .async_i(sync_in),
      .sync_o(sync_out)
   );
   assign lock_s = sync_out[2];
   assign xclk_s = sync_out[1];
   assign vclk_s = sync_out[0];
   ////////////////////////////////////////////////////////////////////
   // Decode and derived terms
   always_comb begin
      wr_ctrl = wr_i && (addr_i == PLL_CTRL_ADDR);
      wr_bw = wr_i && (addr_i == BW_CTRL_ADDR);
      wr_prog = wr_i && (addr_i == PROG_ADDR);
      rd_ctrl = rd_i && (addr_i == PLL_CTRL_ADDR);
      // Toggle between two samples
      toggle = lock_s ^ lock_prev_r;
      vrs_ok = (vrs_r != FIELD_ZERO);
   end
   ////////////////////////////////////////////////////////////////////
   // Control and programming next values
   always_comb begin
      ie_nxt = ie_r;
      on_nxt = on_r;
      bcs_nxt = bcs_r;
      auto_nxt = auto_r;
      mul_nxt = mul_r;
      vrs_nxt = vrs_r;
      lock_prev_nxt = lock_s;
      vrs_eff = vrs_r;
      // Programming fields locked while the PLL runs
      if (wr_prog && !on_r) begin
         mul_nxt = wdata_i[MUL_HI:MUL_LO];
         vrs_nxt = wdata_i[VRS_HI:VRS_LO];
         vrs_eff = wdata_i[VRS_HI:VRS_LO];
      end
      // Mode bit, always writable
      if (wr_bw) begin
         auto_nxt = wdata_i[AUTO_BIT];
      end
      // Control byte
      if (wr_ctrl) begin
         // Enable writable only in automatic mode
         if (auto_r) begin
            ie_nxt = wdata_i[IE_BIT];
         end
         // Clearing power ignored while VCO is or becomes selected
         if (wdata_i[ON_BIT] || !(bcs_r || (wdata_i[BCS_BIT] && on_r && vrs_ok))) begin
            on_nxt = wdata_i[ON_BIT];
         end
         // Setting select needs power already on and a valid range
         if (!wdata_i[BCS_BIT]) begin
            bcs_nxt = 1'b0;
         end else if (on_r && vrs_ok) begin
            bcs_nxt = 1'b1;
         end
      end
      // Zero range or stop returns to the crystal
      if (vrs_eff == FIELD_ZERO || stop_i) begin
         bcs_nxt = 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Flag next value: set wins over the read clear
   // A toggle during a read still sets the flag
   always_comb begin
      flag_nxt = flag_r;
      // Any control read clears
      if (rd_ctrl) begin
         flag_nxt = 1'b0;
      end
      if (toggle && auto_r) begin
         flag_nxt = 1'b1;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Read views
   always_comb begin
      // Control byte
      ctrl_view = '0;
      ctrl_view[IE_BIT] = ie_r & auto_r;
      ctrl_view[FLAG_BIT] = flag_r & auto_r;
      ctrl_view[ON_BIT] = on_r;
      ctrl_view[BCS_BIT] = bcs_r;
      ctrl_view[3:0] = CTRL_LOW_ONES;
      // Bandwidth byte
      bw_view = '0;
      bw_view[AUTO_BIT] = auto_r;
      bw_view[LOCK_BIT] = lock_s & auto_r;
      // Programming byte
      prog_view = {mul_r, vrs_r};
      case (addr_i)
         PLL_CTRL_ADDR: rdata_nxt = ctrl_view;
         BW_CTRL_ADDR: rdata_nxt = bw_view;
         PROG_ADDR: rdata_nxt = prog_view;
         default: rdata_nxt = '0; // Unmapped reads zero
      endcase
      // Hold between reads
      if (!rd_i) begin
         rdata_nxt = rdata_r;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Registers
   // Synchronous reset values
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ie_r <= 1'b0;
         flag_r <= 1'b0;
         on_r <= PLL_ON_RST;
         bcs_r <= 1'b0;
         auto_r <= 1'b0;
         mul_r <= MUL_RST;
         vrs_r <= VRS_RST;
         lock_prev_r <= 1'b0;
         rdata_r <= '0;
      end else begin
         ie_r <= ie_nxt;
         flag_r <= flag_nxt;
         on_r <= on_nxt;
         bcs_r <= bcs_nxt;
         auto_r <= auto_nxt;
         mul_r <= mul_nxt;
         vrs_r <= vrs_nxt;
         lock_prev_r <= lock_prev_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // Outputs
   // Read data
   assign rdata_o = rdata_r;
   // Divider never sees zero
   assign fb_divider_o = (mul_r == FIELD_ZERO) ? MUL_ONE : mul_r;
   // Range as written
   assign vco_range_field_o = vrs_r;
   // Oscillator follows enable
   assign osc_run_o = osc_enable_in_i;
   // Power, range and oscillator
   assign pll_enable_o = on_r & vrs_ok & osc_enable_in_i;
   // Low in manual mode and with the oscillator disabled
   assign pll_irq_out_o = flag_r & ie_r & auto_r & osc_enable_in_i;
   // Source switch and divider
   clk_switch u_switch (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .xclk_i(xclk_s),
      .vclk_i(vclk_s),
      .vco_live_i(pll_enable_o),
      .osc_en_i(osc_enable_in_i),
      .sel_i(bcs_r),
      .base_clock_o(base_clock_out_o),
      .busy_o(switch_busy_o)
   );
   ////////////////////////////////////////////////////////////////////
   // Checks
   // Zero multiplier as one
   AST_MUL_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_prog && !on_r && wdata_i[MUL_HI:MUL_LO] == FIELD_ZERO |=> fb_divider_o == MUL_ONE)
      else $error("zero multiplier did not act as one");
   // Zero range: PLL off, crystal
   AST_VRS_ZERO: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      vrs_r == FIELD_ZERO |-> !bcs_r && !pll_enable_o)
      else $error("zero range left PLL enabled or VCO selected");
   // Select refused while off
   AST_BCS_NEEDS_ON: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_ctrl && wdata_i[BCS_BIT] && !on_r |=> !bcs_r)
      else $error("select taken while PLL off");
   // Power held under the VCO
   AST_ON_HELD: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_ctrl && !wdata_i[ON_BIT] && bcs_r |=> on_r)
      else $error("PLL turned off while VCO selected");
   // Select always has power
   AST_SEL_POWERED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      bcs_r |-> on_r)
      else $error("VCO selected while PLL off");
   // Power and select apart
   AST_SPLIT_WRITES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      $changed(on_r) |-> $stable(bcs_r))
      else $error("power and select changed together");
   // Oscillator gate
   AST_OSC_GATE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !osc_enable_in_i |-> (!pll_enable_o && !osc_run_o) ##1 !base_clock_out_o)
      else $error("clock ran with the oscillator disabled");
   // Toggle raises interrupt
   AST_IRQ: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      toggle && auto_r && ie_r && !wr_ctrl && !wr_bw |=> pll_irq_out_o || !osc_enable_in_i)
      else $error("lock toggle did not raise the interrupt");
   // Enable frozen in manual
   AST_IE_BLOCKED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_ctrl && !auto_r |=> $stable(ie_r))
      else $error("enable written in manual mode");
   // Manual hides flag, enable
   AST_MANUAL_READS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rd_ctrl && !auto_r |=> !rdata_o[FLAG_BIT] && !rdata_o[IE_BIT])
      else $error("manual mode showed flag or enable");
   // Read clears flag
   AST_READ_CLEARS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rd_ctrl && !(toggle && auto_r) |=> !flag_r)
      else $error("control read did not clear flag");
   // Stop to crystal
   AST_STOP: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      stop_i |=> !bcs_r)
      else $error("stop did not clear select");
   // Unused bits high
   AST_LOW_ONES: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rd_ctrl |=> rdata_o[3:0] == CTRL_LOW_ONES)
      else $error("low control bits not read as ones");
   // Manual lock reads zero
   AST_LOCK_HIDDEN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      rd_i && addr_i == BW_CTRL_ADDR && !auto_r |=> !rdata_o[LOCK_BIT])
      else $error("lock shown in manual mode");
   // Every toggle flagged
   AST_TOGGLE_SETS: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      auto_r && $changed(lock_s) |-> ##1 flag_r)
      else $error("lock toggle lost");
   // Scenarios
   COV_LOCK_IRQ: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      ie_r && auto_r ##[1:50] pll_irq_out_o);
   COV_VCO_SELECT: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      !bcs_r ##1 bcs_r);
   COV_READ_CLEAR: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      flag_r && rd_ctrl ##1 !flag_r);
   COV_POWER_SPLIT: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      !on_r ##1 on_r ##[1:20] bcs_r);
endmodule // pll_ctl
`default_nettype wire

/* siu_model.sv */
/*
 Far-side model: crystal oscillator, VCO and lock detector sampled on
 clk_sys_i, as seen by the base clock selector.
 Assumes the bench drives the oscillator enable and the lock level.
*/
`timescale 1ns/1ns
`default_nettype none
module siu_model #(
   parameter int XP = 12, // Crystal period in system cycles
   parameter int VP = 6 // VCO period in system cycles
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic reset_i,
   // Controls
   input wire logic osc_enable_in_i,
   input wire logic pll_enable_i,
   input wire logic lock_req_i,
   // Analog side
   output logic crystal_clock_o,
   output logic vco_clock_o,
   output logic lock_detect_o
);
   int xcnt_r; // Crystal phase
   int vcnt_r; // VCO phase
   logic lock_r; // Lock detector level
   ////////////////////////////////////////////////////////////////////
   // Oscillator phases; each source stands low while stopped
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !osc_enable_in_i) begin
         xcnt_r <= 0;
         vcnt_r <= 0;
         lock_r <= 1'b0;
      end else begin
         xcnt_r <= (xcnt_r == XP - 1) ? 0 : xcnt_r + 1;
         vcnt_r <= (!pll_enable_i || vcnt_r == VP - 1) ? 0 : vcnt_r + 1;
         lock_r <= lock_req_i;
      end
   end
   // Square waves from the phases
   assign crystal_clock_o = osc_enable_in_i && (xcnt_r < XP / 2);
   assign vco_clock_o = pll_enable_i && (vcnt_r < VP / 2);
   assign lock_detect_o = lock_r;
endmodule // siu_model
`default_nettype wire

/* base_clock_selector_pll_ctl_tb.sv */
/*
 Self-checking bench for pll_ctl: register port, interlocks, base clock
 rate, lock flag and stop handling.
 Assumes siu_model supplies the source clocks and lock level.
*/
`timescale 1ns/1ns
`default_nettype none
module base_clock_selector_pll_ctl_tb;
   import clkgen_pkg::*;
   localparam int XP = 12; // Crystal period
   localparam int VP = 6; // VCO period
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic [1:0] addr_i = 2'h0;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic osc_en = 1'b1;
   logic stop_i = 1'b0;
   logic lock_req = 1'b0;
   logic [7:0] rdata_o;
   logic base_clock_out_o, pll_irq_out_o, pll_enable_o, osc_run_o, switch_busy_o;
   logic xclk, vclk, lock_det;
   logic [3:0] fb_divider_o, vco_range_field_o;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [31:0] rnd = 32'h9175;
   ////////////////////////////////////////////////////////////////////
   // Clock, design and partner
   always #2 clk_sys_i = ~clk_sys_i;
   pll_ctl DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_enable_in_i(osc_en), .stop_i(stop_i),
      .base_clock_out_o(base_clock_out_o), .pll_irq_out_o(pll_irq_out_o), .crystal_clock_i(xclk),
      .vco_clock_i(vclk), .lock_detect_i(lock_det), .pll_enable_o(pll_enable_o),
      .osc_run_o(osc_run_o), .fb_divider_o(fb_divider_o), .vco_range_field_o(vco_range_field_o),
      .switch_busy_o(switch_busy_o));
   siu_model #(.XP(XP), .VP(VP)) partner (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .osc_enable_in_i(osc_en), .pll_enable_i(pll_enable_o), .lock_req_i(lock_req),
      .crystal_clock_o(xclk), .vco_clock_o(vclk), .lock_detect_o(lock_det));
   ////////////////////////////////////////////////////////////////////
   // Expectation helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] ctl(input logic ie, input logic fl, input logic on, input logic base_clock_select);
      return {ie, fl, on, base_clock_select, CTRL_LOW_ONES};
   endfunction
   ////////////////////////////////////////////////////////////////////
   // Compare tasks
   task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk_bit(input string n, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %b seen %b", n, e, g);
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // Register port master
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
   endtask
   // Read, data checked in the cycle after the strobe
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] e, input string n);
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      @(negedge clk_sys_i);
      chk_byte(n, e, rdata_o);
   endtask
   // Bounded wait for the source switch to finish
   task automatic wait_idle();
      int i;
      i = 0;
      repeat (4) @(negedge clk_sys_i);
      while (switch_busy_o !== 1'b0 && i < 400) begin
         @(negedge clk_sys_i);
         i++;
      end
      chk_bit("switch_done", 1'b0, switch_busy_o);
   endtask
   // Count base clock rises against the source period
   task automatic rate_chk(input int period);
      int n;
      int e;
      logic prev;
      n = 0;
      e = 240 / (2 * period);
      prev = base_clock_out_o;
      repeat (240) begin
         @(negedge clk_sys_i);
         if (base_clock_out_o === 1'b1 && prev === 1'b0) n++;
         prev = base_clock_out_o;
      end
      chk_bit("base_clock_rate", 1'b1, n >= e - 1 && n <= e + 1);
   endtask
   task automatic do_reset();
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_mismatch++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [7:0] v;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      // Reset values and crystal rate
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_reset");
      rd_chk(PROG_ADDR, 8'h66, "prog_reset");
      rd_chk(BW_CTRL_ADDR, 8'h00, "bw_reset");
      rd_chk(2'h3, 8'h00, "unmapped");
      chk_byte("fb_reset", 8'h06, {4'h0, fb_divider_o});
      chk_bit("pll_on_reset", 1'b1, pll_enable_o);
      rate_chk(XP);
      $display("test reset done");
      // Manual mode select of the VCO
      wr_reg(PLL_CTRL_ADDR, 8'hFF);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 1), "ctrl_manual_sel");
      wait_idle();
      rate_chk(VP);
      $display("test select done");
      // Power and select interlocks
      wr_reg(PLL_CTRL_ADDR, 8'h00);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_off_blocked");
      wait_idle();
      rate_chk(XP);
      wr_reg(PLL_CTRL_ADDR, 8'h00);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 0, 0), "ctrl_off");
      wr_reg(PLL_CTRL_ADDR, 8'h30);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_sel_blocked");
      wr_reg(PLL_CTRL_ADDR, 8'h30);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 1), "ctrl_second_write");
      wait_idle();
      $display("test interlock done");
      // Stop with the VCO selected, oscillator disabled
      @(posedge clk_sys_i);
      stop_i <= 1'b1;
      osc_en <= 1'b0;
      @(posedge clk_sys_i);
      stop_i <= 1'b0;
      repeat (20) @(negedge clk_sys_i);
      chk_bit("base_stopped", 1'b0, base_clock_out_o);
      chk_bit("pll_gated", 1'b0, pll_enable_o);
      chk_bit("osc_gated", 1'b0, osc_run_o);
      @(posedge clk_sys_i);
      osc_en <= 1'b1;
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_after_stop");
      wait_idle();
      $display("test stop done");
      // Programming register, random values with corners
      wr_reg(PROG_ADDR, 8'h00);
      rd_chk(PROG_ADDR, 8'h66, "prog_protected");
      wr_reg(PLL_CTRL_ADDR, 8'h00);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         v = (i == 0) ? 8'h00 : (i == 5) ? 8'h50 : rnd[7:0];
         wr_reg(PROG_ADDR, v);
         rd_chk(PROG_ADDR, v, "prog_value");
         chk_byte("fb_divider", (v[7:4] == 4'h0) ? 8'h01 : {4'h0, v[7:4]}, {4'h0, fb_divider_o});
         chk_byte("vco_range", {4'h0, v[3:0]}, {4'h0, vco_range_field_o});
      end
      wr_reg(PLL_CTRL_ADDR, 8'h20);
      wr_reg(PLL_CTRL_ADDR, 8'h30);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_zero_range");
      chk_bit("pll_zero_range", 1'b0, pll_enable_o);
      wr_reg(PLL_CTRL_ADDR, 8'h00);
      wr_reg(PROG_ADDR, 8'h66);
      wr_reg(PLL_CTRL_ADDR, 8'h20);
      $display("test program done");
      // Lock flag and interrupt in automatic mode
      wr_reg(BW_CTRL_ADDR, 8'h80);
      wr_reg(PLL_CTRL_ADDR, 8'hA0);
      rd_chk(PLL_CTRL_ADDR, ctl(1, 0, 1, 0), "ctrl_auto_ie");
      @(posedge clk_sys_i);
      lock_req <= 1'b1;
      repeat (8) @(negedge clk_sys_i);
      chk_bit("irq_on_lock", 1'b1, pll_irq_out_o);
      rd_chk(BW_CTRL_ADDR, 8'hC0, "bw_locked");
      rd_chk(PLL_CTRL_ADDR, ctl(1, 1, 1, 0), "ctrl_flag");
      chk_bit("irq_cleared", 1'b0, pll_irq_out_o);
      rd_chk(PLL_CTRL_ADDR, ctl(1, 0, 1, 0), "ctrl_flag_once");
      @(posedge clk_sys_i);
      lock_req <= 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk_bit("irq_on_unlock", 1'b1, pll_irq_out_o);
      wr_reg(BW_CTRL_ADDR, 8'h00);
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_manual_hides");
      chk_bit("irq_manual", 1'b0, pll_irq_out_o);
      @(posedge clk_sys_i);
      lock_req <= 1'b1;
      repeat (8) @(negedge clk_sys_i);
      rd_chk(BW_CTRL_ADDR, 8'h00, "bw_manual_lock");
      $display("test lock done");
      // Second reset in mid-run
      wr_reg(PLL_CTRL_ADDR, 8'h30);
      do_reset();
      rd_chk(PLL_CTRL_ADDR, ctl(0, 0, 1, 0), "ctrl_rereset");
      $display("test rereset done");
      end_sim();
   end
endmodule // base_clock_selector_pll_ctl_tb
`default_nettype wire
